// ### src/cca_pkg.sv
// Constants, register map and types of the counter array with watchdog
package cca_pkg;
    localparam int NUM_MOD = 5;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int WD_MOD = 4;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_WDCTRL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_WDKICK = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_WDRELOAD = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_MODE_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_CMP_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_STRIDE = 8'h04;

    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_SRC_LSB = 1;
    localparam int WD_EN_BIT = 0;
    localparam int WD_LOCK_BIT = 1;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_MOD_LSB = 1;
    localparam int STAT_W = 6;

    // Values after reset
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam logic [15:0] WD_RELOAD_RESET = 16'hff00;
    localparam logic [STAT_W-1:0] MASK_RESET = 6'h00;

    // Prescaler counts
    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;
    localparam int DIV_OSC = 8;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        CCA_SRC_DIV12,
        CCA_SRC_DIV4,
        CCA_SRC_TIMER0,
        CCA_SRC_EXT_COUNT,
        CCA_SRC_SYSCLK,
        CCA_SRC_EXTOSC_DIV8
    } cca_src_type;

    typedef enum logic [2:0] {
        CCA_MODE_OFF,
        CCA_MODE_CAPTURE,
        CCA_MODE_SW_TIMER,
        CCA_MODE_HS_OUTPUT,
        CCA_MODE_PWM8,
        CCA_MODE_PWM16,
        CCA_MODE_FREQ
    } cca_mode_type;

    // Mode register layout: [2:0] mode, [3] capture on rise, [4] capture on fall
    typedef struct packed {
        logic cap_fall;
        logic cap_rise;
        cca_mode_type mode;
    } cca_mod_cfg_type;

    localparam cca_mod_cfg_type MOD_CFG_RESET = '{1'b0, 1'b0, CCA_MODE_OFF};
endpackage : cca_pkg

// ### src/cca_module.sv
// One capture/compare module running against the shared time base
`timescale 1ns/1ps
module cca_module
    import cca_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic active,
    input wire logic tick,
    input wire logic [CNT_W-1:0] count,
    input wire cca_mod_cfg_type cfg,
    input wire logic cmp_wr,
    input wire logic [CNT_W-1:0] cmp_wdata,
    input wire logic pin_in,
    output logic [CNT_W-1:0] cmp_val,
    output logic pin_out,
    output logic event_pulse
);
    logic pin_q;
    logic [7:0] freq_next;
    logic cap_hit;
    logic match;
    logic freq_hit;

    assign cap_hit = active && cfg.mode == CCA_MODE_CAPTURE
        && ((cfg.cap_rise && pin_in && !pin_q) || (cfg.cap_fall && !pin_in && pin_q));
    assign match = tick && count == cmp_val;
    assign freq_hit = tick && cfg.mode == CCA_MODE_FREQ && count[7:0] == freq_next;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_val <= '0;
        end else if (cmp_wr) begin
            cmp_val <= cmp_wdata;
        end else if (cap_hit) begin
            cmp_val <= count;
        end
    end

    // Frequency mode: high byte of the compare value is the half period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_next <= '0;
        end else if (cfg.mode != CCA_MODE_FREQ) begin
            freq_next <= cmp_val[15:8];
        end else if (freq_hit) begin
            freq_next <= 8'(freq_next + cmp_val[15:8]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= 1'b0;
        end else begin
            case (cfg.mode)
                CCA_MODE_HS_OUTPUT: pin_out <= match ? !pin_out : pin_out;
                CCA_MODE_PWM8: pin_out <= count[7:0] < cmp_val[7:0];
                CCA_MODE_PWM16: pin_out <= count < cmp_val;
                CCA_MODE_FREQ: pin_out <= freq_hit ? !pin_out : pin_out;
                default: pin_out <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= cap_hit || freq_hit || (match && cfg.mode inside
                {CCA_MODE_SW_TIMER, CCA_MODE_HS_OUTPUT, CCA_MODE_PWM8, CCA_MODE_PWM16});
        end
    end
endmodule : cca_module

// ### src/cca_array.sv
// Counter array top: time base, clock sources, five modules, watchdog, AXI4-Lite slave
//
// How it works
// - One 16-bit counter is the shared time base of every module.
// - Five capture/compare modules, each configured alone, all reading the counter.
// - Counter clock chosen from sysclk/12, sysclk/4, timer 0, external input, sysclk, osc/8.
// - External oscillator divider runs regardless of the system clock source.
// - Modes: capture, software timer, high-speed output, 8/16-bit PWM, frequency.
// - Module 4 also serves as a watchdog built on the shared counter.
// - Every system reset leaves the watchdog configured and enabled.
// - Watchdog expiry raises a system reset request.
// - Software may disable the watchdog reset source.
// - After power-on, software may lock the watchdog on until next power-on.
// - Debug halt stalls the whole counter array.
// - Module pins and the external count input are routable crossbar signals.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module cca_array
    import cca_pkg::*;
#(
    parameter int N_MOD = NUM_MOD,
    parameter logic [15:0] WD_RELOAD = WD_RELOAD_RESET
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic debug_halt,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_in,
    input wire logic [N_MOD-1:0] cc_in,
    output logic [N_MOD-1:0] cc_out,
    output logic irq,
    output logic wd_reset_request
);
    generate
        if (N_MOD != NUM_MOD) begin : g_bad_count
            $error("cca_array serves exactly five modules, watchdog on module 4");
        end
    endgenerate

    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic [31:0] wr_word;
    logic [32:0] wr_old;
    logic [32:0] rd_word;
    logic rd_take;

    logic run;
    cca_src_type src;
    logic [CNT_W-1:0] count;
    logic [3:0] div12_cnt;
    logic [1:0] div4_cnt;
    logic [2:0] osc_cnt;
    logic osc_q;
    logic eci_q;
    logic raw_event;
    logic active;
    logic tick;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [STAT_W-1:0] next_status;
    logic wd_en;
    logic wd_lock;
    logic [15:0] wd_reload_val;
    logic [CNT_W-1:0] wd_target;
    cca_mod_cfg_type cfg [N_MOD];
    cca_mod_cfg_type cfg_eff [N_MOD];
    logic [CNT_W-1:0] cmp_val [N_MOD];
    logic [N_MOD-1:0] mod_event;

    // Register view for one address; bit 32 marks a mapped address
    function automatic logic [32:0] reg_view(input logic [ADDR_W-1:0] a);
        logic [32:0] v;
        v = '0;
        if (a == ADDR_CTRL) begin
            v = {1'b1, 28'h0000000, src, run};
        end else if (a == ADDR_COUNT) begin
            v = {1'b1, 16'h0000, count};
        end else if (a == ADDR_STATUS) begin
            v = {1'b1, 26'h0000000, status};
        end else if (a == ADDR_MASK) begin
            v = {1'b1, 26'h0000000, mask};
        end else if (a == ADDR_WDCTRL) begin
            v = {1'b1, 30'h00000000, wd_lock, wd_en};
        end else if (a == ADDR_WDKICK) begin
            v = {1'b1, 32'h00000000};
        end else if (a == ADDR_WDRELOAD) begin
            v = {1'b1, 16'h0000, wd_reload_val};
        end else begin
            for (int i = 0; i < N_MOD; i++) begin
                if (a == ADDR_W'(ADDR_MODE_BASE + ADDR_STRIDE * i)) begin
                    v = {1'b1, 27'h0000000, cfg[i]};
                end else if (a == ADDR_W'(ADDR_CMP_BASE + ADDR_STRIDE * i)) begin
                    v = {1'b1, 16'h0000, cmp_val[i]};
                end
            end
        end
        return v;
    endfunction : reg_view

    // Write path: address and data are held separately, then applied together
    assign do_write = !awready && !wready && !bvalid;
    assign rd_take = arvalid && arready;

    always_comb begin
        wr_old = reg_view(aw_addr_q);
        rd_word = reg_view(araddr);
        for (int b = 0; b < 4; b++) begin
            wr_word[8*b +: 8] = w_strb_q[b] ? w_data_q[8*b +: 8] : wr_old[8*b +: 8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_old[32] ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (rd_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word[31:0];
            rresp <= rd_word[32] ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Control and configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run <= CTRL_RUN_RESET;
            src <= CCA_SRC_DIV12;
            mask <= MASK_RESET;
        end else if (do_write && aw_addr_q == ADDR_CTRL) begin
            run <= wr_word[CTRL_RUN_BIT];
            src <= cca_src_type'(wr_word[CTRL_SRC_LSB +: 3]);
        end else if (do_write && aw_addr_q == ADDR_MASK) begin
            mask <= wr_word[STAT_W-1:0];
        end
    end

    // Prescalers are free running so a source switch never waits on a stale phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div12_cnt <= '0;
            div4_cnt <= '0;
            osc_cnt <= '0;
            osc_q <= 1'b0;
            eci_q <= 1'b0;
        end else begin
            div12_cnt <= (div12_cnt == 4'(DIV_SLOW - 1)) ? 4'h0 : 4'(div12_cnt + 1);
            div4_cnt <= 2'(div4_cnt + 1);
            osc_q <= ext_osc_in;
            eci_q <= external_count_input;
            if (ext_osc_in && !osc_q) begin
                osc_cnt <= 3'(osc_cnt + 1);
            end
        end
    end

    always_comb begin
        case (src)
            CCA_SRC_DIV12: raw_event = div12_cnt == 4'(DIV_SLOW - 1);
            CCA_SRC_DIV4: raw_event = div4_cnt == 2'(DIV_FAST - 1);
            CCA_SRC_TIMER0: raw_event = timer0_overflow;
            CCA_SRC_EXT_COUNT: raw_event = external_count_input && !eci_q;
            CCA_SRC_SYSCLK: raw_event = 1'b1;
            CCA_SRC_EXTOSC_DIV8: raw_event = ext_osc_in && !osc_q
                && osc_cnt == 3'(DIV_OSC - 1);
            default: raw_event = 1'b0;
        endcase
    end

    assign active = !debug_halt;
    assign tick = run && active && raw_event;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else if (do_write && aw_addr_q == ADDR_COUNT) begin
            count <= wr_word[CNT_W-1:0];
        end else if (tick) begin
            count <= CNT_W'(count + 1);
        end
    end

    // Status: hardware set wins over the read clear in the same cycle
    always_comb begin
        next_status = rd_take && araddr == ADDR_STATUS ? '0 : status;
        if (tick && count == '1) begin
            next_status[STAT_OVF_BIT] = 1'b1;
        end
        next_status[STAT_MOD_LSB +: N_MOD] = next_status[STAT_MOD_LSB +: N_MOD] | mod_event;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= '0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= |(status & mask);
        end
    end

    // The lock survives system reset; only power-on clears it
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            wd_lock <= 1'b0;
        end else if (do_write && aw_addr_q == ADDR_WDCTRL && wr_word[WD_LOCK_BIT]) begin
            wd_lock <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_en <= 1'b1;
        end else if (do_write && aw_addr_q == ADDR_WDCTRL) begin
            wd_en <= wr_word[WD_EN_BIT] || wr_word[WD_LOCK_BIT] || wd_lock;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_reload_val <= WD_RELOAD;
            wd_target <= WD_RELOAD;
        end else begin
            if (do_write && aw_addr_q == ADDR_WDRELOAD) begin
                wd_reload_val <= wr_word[15:0];
            end
            if (do_write && aw_addr_q == ADDR_WDKICK) begin
                wd_target <= CNT_W'(count + wd_reload_val);
            end
        end
    end

    // Request stays up until the system reset it causes arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_reset_request <= 1'b0;
        end else if (wd_en && tick && count == wd_target) begin
            wd_reset_request <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N_MOD; i++) begin
                cfg[i] <= MOD_CFG_RESET;
            end
        end else if (do_write) begin
            for (int i = 0; i < N_MOD; i++) begin
                if (aw_addr_q == ADDR_W'(ADDR_MODE_BASE + ADDR_STRIDE * i)) begin
                    cfg[i] <= cca_mod_cfg_type'(wr_word[4:0]);
                end
            end
        end
    end

    generate
        for (genvar g = 0; g < N_MOD; g++) begin : g_mod
            // Module 4 gives up its ordinary mode while it serves as watchdog
            assign cfg_eff[g] = (g == WD_MOD && wd_en) ? MOD_CFG_RESET : cfg[g];

            cca_module u_mod (
                .aclk(aclk),
                .aresetn(aresetn),
                .active(active),
                .tick(tick),
                .count(count),
                .cfg(cfg_eff[g]),
                .cmp_wr(do_write && aw_addr_q == ADDR_W'(ADDR_CMP_BASE + ADDR_STRIDE * g)),
                .cmp_wdata(wr_word[CNT_W-1:0]),
                .pin_in(cc_in[g]),
                .cmp_val(cmp_val[g]),
                .pin_out(cc_out[g]),
                .event_pulse(mod_event[g])
            );
        end
    endgenerate
endmodule : cca_array

// ### verif/cca_array_asserts.sv
// Port-level checker for the counter array with watchdog
`timescale 1ns/1ps
module cca_array_asserts
    import cca_pkg::*;
#(
    parameter int N_MOD = NUM_MOD
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic debug_halt,
    input wire logic [N_MOD-1:0] cc_out,
    input wire logic irq,
    input wire logic wd_reset_request
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    // Four quiet cycles so that no register write can still ripple into the pins
    sequence s_quiet;
        (debug_halt && awready && !bvalid) [*4];
    endsequence

    reset_state_a: assert property (
        $rose(aresetn) |-> awready && wready && arready && !bvalid && !rvalid && !irq
            && !wd_reset_request && cc_out == '0) else $error("bad state after reset");
    wd_hold_a: assert property (
        wd_reset_request |=> wd_reset_request) else $error("reset request dropped");
    halt_stall_a: assert property (
        s_quiet |-> $stable(cc_out) && $stable(wd_reset_request)) else $error("moved in halt");
    write_answer_a: assert property (
        s_wr_take |=> !awready && !wready ##1 bvalid) else $error("write answer late");
    write_close_a: assert property (
        bvalid && bready |=> !bvalid && awready && wready) else $error("write not closed");
    read_answer_a: assert property (
        arvalid && arready |=> !arready && rvalid) else $error("read answer late");
    read_close_a: assert property (
        rvalid && rready |=> !rvalid && arready) else $error("read not closed");
    read_excl_a: assert property (
        rvalid |-> !arready) else $error("address taken during read");
endmodule : cca_array_asserts

bind cca_array cca_array_asserts #(.N_MOD(N_MOD)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
    .debug_halt(debug_halt), .cc_out(cc_out), .irq(irq), .wd_reset_request(wd_reset_request)
);

// ### verif/cca_far_model.sv
// Event sources beside the counter array: timer 0, external count input, external oscillator
`timescale 1ns/1ps
module cca_far_model (
    input wire logic aclk,
    output logic timer0_overflow,
    output logic external_count_input,
    output logic ext_osc_in
);
    int unsigned n;

    initial begin
        n = 0;
        timer0_overflow = 1'b0;
        external_count_input = 1'b0;
        ext_osc_in = 1'b0;
    end

    // Fixed periods (5, 6 and 2 cycles) so the bench can predict counts per source
    always @(posedge aclk) begin
        n <= n + 1;
        timer0_overflow <= (n % 5 == 4);
        external_count_input <= (n % 6 < 3);
        ext_osc_in <= n[0];
    end
endmodule : cca_far_model

// ### verif/cca_array_tb.sv
// Register-level testbench of the counter array with watchdog
`timescale 1ns/1ps
module cca_array_tb
    import cca_pkg::*;
();
    logic aclk, aresetn, por_n, awvalid, wvalid, bready, arvalid, rready, debug_halt;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data, c1;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, wr_resp, rd_resp;
    logic awready, wready, bvalid, arready, rvalid, irq, wd_reset_request;
    logic timer0_overflow, external_count_input, ext_osc_in;
    logic [4:0] cc_in, cc_out;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int divs [6] = '{12, 4, 5, 6, 1, 16};

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Short reload keeps the expiry scenario brief
    cca_array #(.N_MOD(5), .WD_RELOAD(16'h0010)) dut (
        .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .debug_halt(debug_halt), .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input), .ext_osc_in(ext_osc_in),
        .cc_in(cc_in), .cc_out(cc_out), .irq(irq), .wd_reset_request(wd_reset_request));

    cca_far_model far (.aclk(aclk), .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input), .ext_osc_in(ext_osc_in));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_left;
        logic w_left;
        @(posedge aclk);
        aw_left = 1'b1;
        w_left = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (aw_left && awready) begin
                aw_left = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_left && wready) begin
                w_left = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(what, rd_data, exp);
    endtask : rc

    // System reset alone leaves the watchdog lock; por also clears it
    task automatic rst(input logic por);
        @(posedge aclk);
        aresetn <= 1'b0;
        por_n <= ~por;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
    endtask : rst

    initial begin
        {aresetn, por_n, awvalid, wvalid, bready, arvalid, rready, debug_halt} = '0;
        {awaddr, araddr, wdata, wstrb, cc_in} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        rc("ctrl", ADDR_CTRL, 32'h1);
        rc("wdctrl", ADDR_WDCTRL, 32'h1);
        rc("wdreload", ADDR_WDRELOAD, 32'h10);
        rc("unmapped", 8'hfc, 32'h0);
        chk("rresp", 32'(rd_resp), 32'(RESP_SLVERR));
        wr(8'hfc, 32'h1);
        chk("bresp", 32'(wr_resp), 32'(RESP_SLVERR));
        repeat (250) @(posedge aclk);
        chk("expiry", wd_reset_request, 1);
        rst(1'b0);
        chk("cleared", wd_reset_request, 0);
        wr(ADDR_WDCTRL, 0);
        rc("wd off", ADDR_WDCTRL, 0);
        repeat (300) @(posedge aclk);
        chk("no expiry", wd_reset_request, 0);
        $display("test watchdog done");
        for (int m = 0; m < 7; m++) begin
            wr(ADDR_MODE_BASE, 32'(m));
            rc("mode", ADDR_MODE_BASE, 32'(m));
        end
        wr(ADDR_CTRL, 0);
        wr(ADDR_COUNT, 32'h10);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_MODE_BASE + 8'(4 * i), 32'(CCA_MODE_PWM8));
            wr(ADDR_CMP_BASE + 8'(4 * i), 32'h80);
        end
        repeat (3) @(posedge aclk);
        chk("pwm high", cc_out, 5'h1f);
        wr(ADDR_COUNT, 32'h90);
        repeat (3) @(posedge aclk);
        chk("pwm low", cc_out, 5'h00);
        wr(ADDR_COUNT, 32'h10);
        wr(ADDR_WDCTRL, 1);
        repeat (3) @(posedge aclk);
        chk("wd owns mod4", cc_out, 5'h0f);
        wr(ADDR_WDCTRL, 0);
        wr(ADDR_MODE_BASE, 32'h9);
        wr(ADDR_COUNT, 32'h1234);
        cc_in <= 5'h01;
        repeat (4) @(posedge aclk);
        rc("capture", ADDR_CMP_BASE, 32'h1234);
        rd(ADDR_STATUS);
        chk("cap flag", rd_data[1], 1);
        cc_in <= 5'h00;
        $display("test modules done");
        for (int s = 0; s < 6; s++) begin
            wr(ADDR_CTRL, 32'(s) << 1);
            wr(ADDR_COUNT, 0);
            wr(ADDR_CTRL, (32'(s) << 1) | 32'h1);
            repeat (240) @(posedge aclk);
            wr(ADDR_CTRL, 32'(s) << 1);
            rd(ADDR_COUNT);
            chk("rate", rd_data + 2 >= 244 / divs[s] && rd_data <= 244 / divs[s] + 2, 1);
        end
        $display("test sources done");
        wr(ADDR_CTRL, 32'h9);
        debug_halt <= 1'b1;
        rd(ADDR_COUNT);
        c1 = rd_data;
        repeat (20) @(posedge aclk);
        rc("halted", ADDR_COUNT, c1);
        debug_halt <= 1'b0;
        wr(ADDR_CTRL, 32'h8);
        rd(ADDR_STATUS);
        wr(ADDR_MASK, 0);
        wr(ADDR_COUNT, 32'hfff0);
        wr(ADDR_CTRL, 32'h9);
        repeat (40) @(posedge aclk);
        chk("masked irq", irq, 0);
        wr(ADDR_CTRL, 32'h8);
        wr(ADDR_MASK, 1);
        repeat (3) @(posedge aclk);
        chk("irq", irq, 1);
        rd(ADDR_STATUS);
        chk("ovf flag", rd_data[0], 1);
        repeat (3) @(posedge aclk);
        chk("irq cleared", irq, 0);
        $display("test halt and overflow done");
        wr(ADDR_WDCTRL, 32'h3);
        wr(ADDR_WDCTRL, 0);
        rc("locked", ADDR_WDCTRL, 32'h3);
        rst(1'b0);
        wr(ADDR_WDCTRL, 0);
        rc("lock kept", ADDR_WDCTRL, 32'h3);
        // Without the kick the short reload would expire well inside this wait
        wr(ADDR_WDRELOAD, 32'h100);
        rc("reload", ADDR_WDRELOAD, 32'h100);
        wr(ADDR_WDKICK, 0);
        repeat (250) @(posedge aclk);
        chk("kicked", wd_reset_request, 0);
        rst(1'b1);
        wr(ADDR_WDCTRL, 0);
        rc("lock freed", ADDR_WDCTRL, 0);
        $display("test lock done");
        give_verdict();
    end
endmodule : cca_array_tb
